// ===== synth_cfg.svh
`ifndef SYNTH_CFG_SVH
`define SYNTH_CFG_SVH

// register byte offsets on the AXI4-Lite bus
`define REG_CHANCFG_OFF 8'h00
`define REG_ENABLE_OFF 8'h04
`define REG_VOLUME_OFF 8'h08
`define REG_CHSEL_OFF 8'h0c
`define REG_ENVLOW_OFF 8'h10
`define REG_ENVHIGH_OFF 8'h14
`define REG_POINTER_OFF 8'h18
`define REG_COMMAND_OFF 8'h1c
`define REG_STATUS_OFF 8'h20

// enable register fields
`define EN_AUDIO_BIT 1
`define EN_NOISE_BIT 2
`define EN_MIXER_BIT 3

// command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_ADDR_LSB 8
`define CMD_ADDR_MSB 27

// command opcodes
`define OP_BANK0 4'h1
`define OP_BANK1 4'h2
`define OP_TEST_HEAD_ACTIVE 4'h3
`define OP_TEST_HEAD_IDLE 4'h4
`define OP_TEST_ACTIVE 4'h5
`define OP_TEST_IDLE 4'h6
`define OP_TEST_ALL_IDLE 4'h7
`define OP_STOP 4'h8
`define OP_LOAD_STEP 4'h9
`define OP_READ_MIX 4'ha
`define OP_WRITE_MIX 4'hb
`define OP_BEGIN_IMM 4'hc
`define OP_BEGIN 4'hd

// output modes in chancfg[3:2]
`define MODE_DAC 2'h2

// widths and counts
`define NUM_CHAN 8
`define STEP_W 14
`define MIX_W 13
`define ADDR_W 24
`define FRAC_W 12

// push-pull ramp: 100 us at 10 MHz, longest time rounds down
`define RAMP_TIME_US 100
`define CLK_MHZ 10
`define RAMP_CYCLES (`RAMP_TIME_US * `CLK_MHZ)

`endif

// ===== synth_pkg.sv
package synth_pkg;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_e;
endpackage

// ===== step_mem.sv
`timescale 1ns/10ps
`include "synth_cfg.svh"

module step_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [`STEP_W-1:0] wr_data_i,
  // read port, data one cycle later
  input wire logic [2:0] rd_addr_i,
  output logic [`STEP_W-1:0] rd_data_o
);
  logic [`STEP_W-1:0] mem [`NUM_CHAN];
  logic [`STEP_W-1:0] next_rd_data;

  // read data registered so the adder downstream sees a clean value
  always_comb begin
    next_rd_data = mem[rd_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end
endmodule

// ===== synth_channel_playback_control.sv
`timescale 1ns/10ps
`include "synth_cfg.svh"

module synth_channel_playback_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // waveform engine events
  input wire logic [`NUM_CHAN-1:0] head_done_i,
  input wire logic [`NUM_CHAN-1:0] tail_start_i,
  input wire logic [`NUM_CHAN-1:0] tail_done_i,
  // step accumulation request from the sequencer
  input wire logic advance_req_i,
  input wire logic [2:0] advance_chan_i,
  output logic advance_valid_o,
  output logic [2:0] advance_chan_o,
  output logic [2:0] advance_count_o,
  // mixer sample from the mixer
  input wire logic mix_valid_i,
  input wire logic [`MIX_W-1:0] mix_sample_i,
  // audio output stage
  output logic [`MIX_W-1:0] mix_data_o,
  output logic mixer_en_o,
  output logic audio_en_o,
  output logic noise_filter_o,
  output logic [1:0] output_mode_o,
  output logic [3:0] active_chan_count_o,
  output logic [3:0] volume_o,
  output logic ramp_active_o,
  // playback control toward the engine
  output logic play_start_o,
  output logic play_stop_o,
  output logic [2:0] play_chan_o,
  output logic [`ADDR_W-1:0] play_addr_o,
  output logic bank_o,
  output logic [`NUM_CHAN-1:0] playing_o,
  output logic env_wr_o,
  output logic [2:0] env_chan_o,
  output logic [7:0] env_data_o
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [10:0] RAMP_LAST = 11'(`RAMP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  synth_pkg::wr_state_e wr_state, next_wr_state;
  synth_pkg::rd_state_e rd_state, next_rd_state;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [31:0] rdata, next_rdata;
  logic wr_fire;
  logic [31:0] rd_word;

  // address and data are taken in either order, then one write commits
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_state = wr_state;
    wr_fire = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    unique case (wr_state)
      synth_pkg::WR_IDLE: begin
        if (aw_held && w_held) begin
          wr_fire = 1'b1;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_state = synth_pkg::WR_RESP;
        end
      end
      synth_pkg::WR_RESP: begin
        if (s_axi_bready_i) begin
          next_wr_state = synth_pkg::WR_IDLE;
        end
      end
    endcase
  end

  assign s_axi_awready_o = !aw_held && (wr_state == synth_pkg::WR_IDLE);
  assign s_axi_wready_o = !w_held && (wr_state == synth_pkg::WR_IDLE);
  assign s_axi_bvalid_o = (wr_state == synth_pkg::WR_RESP);
  assign s_axi_bresp_o = RESP_OKAY;

  // reads answer one cycle after the address is taken
  always_comb begin
    next_rd_state = rd_state;
    next_rdata = rdata;
    unique case (rd_state)
      synth_pkg::RD_IDLE: begin
        if (s_axi_arvalid_i) begin
          next_rdata = rd_word;
          next_rd_state = synth_pkg::RD_RESP;
        end
      end
      synth_pkg::RD_RESP: begin
        if (s_axi_rready_i) begin
          next_rd_state = synth_pkg::RD_IDLE;
        end
      end
    endcase
  end

  assign s_axi_arready_o = (rd_state == synth_pkg::RD_IDLE);
  assign s_axi_rvalid_o = (rd_state == synth_pkg::RD_RESP);
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = RESP_OKAY;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_state <= synth_pkg::WR_IDLE;
      rd_state <= synth_pkg::RD_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      rdata <= '0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and command decode

  logic [3:0] chancfg, next_chancfg;
  logic [3:0] enable, next_enable;
  logic [3:0] volume, next_volume;
  logic [2:0] chan_sel, next_chan_sel;
  logic [3:0] env_low, next_env_low;
  logic [`ADDR_W-1:0] pointer, next_pointer;
  logic bank, next_bank;
  logic test_result, next_test_result;
  logic [`MIX_W-1:0] mix_reg, next_mix_reg;
  logic [`NUM_CHAN-1:0] head_flag, next_head_flag;
  logic [`NUM_CHAN-1:0] tail_flag, next_tail_flag;
  logic [`NUM_CHAN-1:0] playing;
  logic next_start, next_stop, next_env_wr;
  logic [`ADDR_W-1:0] next_play_addr;
  logic [7:0] next_env_data;
  logic step_wr;
  logic [31:0] wd;
  logic [3:0] op;
  logic cmd_fire;
  logic audio_rise;
  logic [10:0] ramp_cnt, next_ramp_cnt;
  logic ramp_busy, next_ramp_busy;

  // only strobed bytes count, unstrobed bytes write as zero; registers here are narrow
  assign wd = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}} & w_data;
  assign op = wd[`CMD_OP_MSB:`CMD_OP_LSB];
  assign cmd_fire = wr_fire && (aw_addr == `REG_COMMAND_OFF);
  assign playing = head_flag | tail_flag;

  // register readback; bank and head flags have no read path
  always_comb begin
    rd_word = '0;
    unique case (s_axi_araddr_i)
      `REG_CHANCFG_OFF: rd_word = {28'h0000000, chancfg};
      `REG_ENABLE_OFF: rd_word = {28'h0000000, enable};
      `REG_VOLUME_OFF: rd_word = {28'h0000000, volume};
      `REG_CHSEL_OFF: rd_word = {29'h00000000, chan_sel};
      `REG_ENVLOW_OFF: rd_word = {28'h0000000, env_low};
      `REG_POINTER_OFF: rd_word = {8'h00, pointer};
      `REG_STATUS_OFF: rd_word = {30'h00000000, ramp_busy, test_result};
      default: rd_word = '0;
    endcase
  end

  // register writes, commands and playback flags
  always_comb begin
    next_chancfg = chancfg;
    next_enable = enable;
    next_volume = volume;
    next_chan_sel = chan_sel;
    next_env_low = env_low;
    next_pointer = pointer;
    next_bank = bank;
    next_test_result = test_result;
    next_mix_reg = mix_reg;
    next_start = 1'b0;
    next_stop = 1'b0;
    next_env_wr = 1'b0;
    next_env_data = env_data_o;
    next_play_addr = play_addr_o;
    step_wr = 1'b0;
    // done events clear flags, tail starts set them; begin and stop below override them
    next_head_flag = head_flag & ~head_done_i;
    next_tail_flag = (tail_flag & ~tail_done_i) | tail_start_i;
    // mixer output latched only while the mixer runs
    if (enable[`EN_MIXER_BIT] && mix_valid_i) begin
      next_mix_reg = mix_sample_i;
    end
    if (wr_fire) begin
      unique case (aw_addr)
        `REG_CHANCFG_OFF: next_chancfg = wd[3:0];
        `REG_ENABLE_OFF: next_enable = {wd[3:1], 1'b0};
        `REG_VOLUME_OFF: next_volume = wd[3:0];
        `REG_CHSEL_OFF: next_chan_sel = wd[2:0];
        `REG_ENVLOW_OFF: next_env_low = wd[3:0];
        `REG_ENVHIGH_OFF: begin
          next_env_wr = 1'b1;
          next_env_data = {wd[3:0], env_low};
        end
        `REG_POINTER_OFF: next_pointer = wd[`ADDR_W-1:0];
        default: ;
      endcase
    end
    if (cmd_fire) begin
      unique case (op)
        `OP_BANK0: next_bank = 1'b0;
        `OP_BANK1: next_bank = 1'b1;
        `OP_TEST_HEAD_ACTIVE: next_test_result = head_flag[chan_sel];
        `OP_TEST_HEAD_IDLE: next_test_result = !head_flag[chan_sel];
        `OP_TEST_ACTIVE: next_test_result = playing[chan_sel];
        `OP_TEST_IDLE: next_test_result = !playing[chan_sel];
        `OP_TEST_ALL_IDLE: next_test_result = (playing == '0);
        `OP_STOP: begin
          next_stop = 1'b1;
          next_head_flag[chan_sel] = 1'b0;
          next_tail_flag[chan_sel] = 1'b0;
        end
        `OP_LOAD_STEP: step_wr = 1'b1;
        `OP_READ_MIX: begin
          if (enable[`EN_MIXER_BIT]) begin
            next_pointer[`MIX_W-1:0] = mix_reg;
          end
        end
        `OP_WRITE_MIX: begin
          // ignored while the mixer owns the register
          if (!enable[`EN_MIXER_BIT]) begin
            next_mix_reg = pointer[`MIX_W-1:0];
          end
        end
        `OP_BEGIN_IMM, `OP_BEGIN: begin
          next_start = 1'b1;
          next_play_addr = (op == `OP_BEGIN_IMM) ?
            {wd[`CMD_ADDR_MSB:`CMD_ADDR_LSB], 4'h0} : {pointer[`ADDR_W-1:4], 4'h0};
          next_head_flag[chan_sel] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // push-pull ramp runs 100 us after audio turns on; dac and pwm skip it
  assign audio_rise = next_enable[`EN_AUDIO_BIT] && !enable[`EN_AUDIO_BIT];
  always_comb begin
    next_ramp_busy = ramp_busy;
    next_ramp_cnt = ramp_cnt;
    if (audio_rise && !chancfg[3]) begin
      next_ramp_busy = 1'b1;
      next_ramp_cnt = '0;
    end else if (ramp_busy) begin
      next_ramp_cnt = ramp_cnt + 11'h001;
      if (ramp_cnt == RAMP_LAST || !enable[`EN_AUDIO_BIT]) begin
        next_ramp_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      chancfg <= '0;
      enable <= '0;
      volume <= '0;
      chan_sel <= '0;
      env_low <= '0;
      pointer <= '0;
      bank <= 1'b0;
      test_result <= 1'b0;
      mix_reg <= '0;
      head_flag <= '0;
      tail_flag <= '0;
      play_start_o <= 1'b0;
      play_stop_o <= 1'b0;
      play_chan_o <= '0;
      play_addr_o <= '0;
      env_wr_o <= 1'b0;
      env_chan_o <= '0;
      env_data_o <= '0;
      ramp_busy <= 1'b0;
      ramp_cnt <= '0;
    end else begin
      chancfg <= next_chancfg;
      enable <= next_enable;
      volume <= next_volume;
      chan_sel <= next_chan_sel;
      env_low <= next_env_low;
      pointer <= next_pointer;
      bank <= next_bank;
      test_result <= next_test_result;
      mix_reg <= next_mix_reg;
      head_flag <= next_head_flag;
      tail_flag <= next_tail_flag;
      play_start_o <= next_start;
      play_stop_o <= next_stop;
      play_chan_o <= chan_sel;
      play_addr_o <= next_play_addr;
      env_wr_o <= next_env_wr;
      env_chan_o <= chan_sel;
      env_data_o <= next_env_data;
      ramp_busy <= next_ramp_busy;
      ramp_cnt <= next_ramp_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step store and fractional position accumulation

  logic [`STEP_W-1:0] step_rd;
  logic adv_pend;
  logic [2:0] adv_chan;
  logic [`FRAC_W-1:0] frac [`NUM_CHAN];
  logic [`FRAC_W+2:0] sum;

  step_mem u_step_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_en_i(step_wr),
    .wr_addr_i(chan_sel),
    .wr_data_i(pointer[`STEP_W-1:0]),
    .rd_addr_i(advance_chan_i),
    .rd_data_o(step_rd)
  );

  // remainder is kept per channel so rate error never builds up
  assign sum = {3'h0, frac[adv_chan]} + {1'b0, step_rd};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      adv_pend <= 1'b0;
      adv_chan <= '0;
      advance_valid_o <= 1'b0;
      advance_chan_o <= '0;
      advance_count_o <= '0;
      for (int i = 0; i < `NUM_CHAN; i++) begin
        frac[i] <= '0;
      end
    end else begin
      adv_pend <= advance_req_i;
      adv_chan <= advance_chan_i;
      advance_valid_o <= adv_pend;
      advance_chan_o <= adv_chan;
      if (adv_pend) begin
        frac[adv_chan] <= sum[`FRAC_W-1:0];
        advance_count_o <= sum[`FRAC_W+2:`FRAC_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the audio stage

  assign mix_data_o = mix_reg;
  assign mixer_en_o = enable[`EN_MIXER_BIT];
  assign audio_en_o = enable[`EN_AUDIO_BIT];
  assign noise_filter_o = enable[`EN_NOISE_BIT];
  assign output_mode_o = chancfg[3:2];
  assign volume_o = volume;
  assign ramp_active_o = ramp_busy;
  assign bank_o = bank;
  assign playing_o = playing;
  // count code 0..3 maps to 8, 6, 4, 2 channels
  assign active_chan_count_o = 4'h8 - {1'b0, chancfg[1:0], 1'b0};
endmodule

// ===== synth_engine_model.sv
`timescale 1ns/10ps
`include "synth_cfg.svh"

module synth_engine_model #(
  parameter int HEAD_LEN = 40,
  parameter int TAIL_LEN = 60
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // playback control from the block
  input wire logic play_start_i,
  input wire logic play_stop_i,
  input wire logic [2:0] play_chan_i,
  input wire logic tail_en_i,
  // waveform events back to the block
  output logic [`NUM_CHAN-1:0] head_done_o,
  output logic [`NUM_CHAN-1:0] tail_start_o,
  output logic [`NUM_CHAN-1:0] tail_done_o
);
  int cnt;
  logic [1:0] phase;
  logic [2:0] ch;

  // one voice at a time is enough here; a stop drops it without any end event
  always @(posedge clk_i) begin
    head_done_o <= '0;
    tail_start_o <= '0;
    tail_done_o <= '0;
    if (reset_i) begin
      phase <= 2'h0;
    end else if (play_start_i) begin
      phase <= 2'h1;
      ch <= play_chan_i;
      cnt <= HEAD_LEN;
    end else if (play_stop_i) begin
      phase <= 2'h0;
    end else if (phase != 2'h0) begin
      if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (phase == 2'h1) begin
        head_done_o[ch] <= 1'b1;
        phase <= tail_en_i ? 2'h2 : 2'h0;
        tail_start_o[ch] <= tail_en_i;
        cnt <= TAIL_LEN;
      end else begin
        tail_done_o[ch] <= 1'b1;
        phase <= 2'h0;
      end
    end
  end
endmodule

// ===== synth_checker_properties.sv
`timescale 1ns/10ps
`include "synth_cfg.svh"

module synth_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bus handshakes
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  // step and mixer
  input wire logic advance_req_i,
  input wire logic [2:0] advance_chan_i,
  input wire logic advance_valid_o,
  input wire logic [2:0] advance_chan_o,
  input wire logic mix_valid_i,
  input wire logic [`MIX_W-1:0] mix_sample_i,
  input wire logic [`MIX_W-1:0] mix_data_o,
  input wire logic mixer_en_o,
  // audio stage and playback
  input wire logic ramp_active_o,
  input wire logic [1:0] output_mode_o,
  input wire logic [3:0] active_chan_count_o,
  input wire logic play_start_o,
  input wire logic play_stop_o,
  input wire logic [2:0] play_chan_o,
  input wire logic [`ADDR_W-1:0] play_addr_o,
  input wire logic [`NUM_CHAN-1:0] playing_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic [10:0] ramp_len;
  // ramp age in cycles
  always_ff @(posedge clk_i) begin
    ramp_len <= ramp_active_o ? ramp_len + 11'h001 : 11'h000;
  end

  // a step request and the answer two cycles on
  sequence step_req;
    advance_req_i;
  endsequence
  sequence step_ans;
    ##2 advance_valid_o;
  endsequence

  a_step_latency: assert property (step_req |-> step_ans)
    else $error("step answer missing");
  a_step_channel: assert property (step_req |-> ##2 advance_chan_o == $past(advance_chan_i, 2))
    else $error("step answer on wrong channel");
  a_mix_latch: assert property (mixer_en_o && mix_valid_i |=> mix_data_o == $past(mix_sample_i))
    else $error("mixer sample not latched");
  a_start_flags: assert property (play_start_o |-> ##[0:1] playing_o[play_chan_o])
    else $error("start did not raise playing flag");
  a_stop_clears: assert property (play_stop_o |-> ##[0:1] !playing_o[play_chan_o])
    else $error("stop did not clear playing flag");
  a_start_aligned: assert property (play_start_o |-> play_addr_o[3:0] == 4'h0)
    else $error("start address not aligned");
  a_chan_count: assert property (active_chan_count_o inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("illegal channel count");
  // an abort by audio off would end early
  a_ramp_length: assert property ($fell(ramp_active_o) |-> ramp_len == 11'(`RAMP_CYCLES))
    else $error("ramp length wrong");
  a_ramp_mode: assert property (ramp_active_o |-> !output_mode_o[1])
    else $error("ramp outside push-pull mode");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_write_okay: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0)
    else $error("write response not okay");
endmodule

bind synth_channel_playback_control synth_checker u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .advance_req_i(advance_req_i), .advance_chan_i(advance_chan_i),
  .advance_valid_o(advance_valid_o), .advance_chan_o(advance_chan_o),
  .mix_valid_i(mix_valid_i), .mix_sample_i(mix_sample_i), .mix_data_o(mix_data_o),
  .mixer_en_o(mixer_en_o), .ramp_active_o(ramp_active_o), .output_mode_o(output_mode_o),
  .active_chan_count_o(active_chan_count_o), .play_start_o(play_start_o),
  .play_stop_o(play_stop_o), .play_chan_o(play_chan_o), .play_addr_o(play_addr_o),
  .playing_o(playing_o)
);

// ===== synth_channel_playback_control_bench.sv
`timescale 1ns/10ps
`include "synth_cfg.svh"

module synth_channel_playback_control_bench;
  localparam int HEAD_LEN = 40;
  localparam int TAIL_LEN = 60;
  localparam int MAX_CYC = 20000;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv, seed = 32'd88, r, s, p;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, adv_valid, mixer_en, ramp, bank;
  logic play_start, play_stop, env_wr, aud;
  logic adv_req = 1'b0, mix_valid = 1'b0;
  logic [2:0] adv_chan = 3'h0, adv_chan_o, adv_count, play_chan, env_chan, c;
  logic [12:0] mix_sample = 13'h0, mix_data;
  logic [7:0] head_done, tail_start, tail_done, playing, env_data;
  logic [1:0] mode;
  logic [3:0] count, volume;
  logic [23:0] play_addr, last_addr;
  logic [10:0] last_env;
  int num_errors = 0, samples_checked = 0, cyc = 0, starts = 0, envs = 0, adv_sum = 0;

  synth_channel_playback_control uut (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .head_done_i(head_done), .tail_start_i(tail_start), .tail_done_i(tail_done),
    .advance_req_i(adv_req), .advance_chan_i(adv_chan), .advance_valid_o(adv_valid),
    .advance_chan_o(adv_chan_o), .advance_count_o(adv_count), .mix_valid_i(mix_valid),
    .mix_sample_i(mix_sample), .mix_data_o(mix_data), .mixer_en_o(mixer_en),
    .audio_en_o(aud), .noise_filter_o(), .output_mode_o(mode), .active_chan_count_o(count),
    .volume_o(volume), .ramp_active_o(ramp), .play_start_o(play_start),
    .play_stop_o(play_stop), .play_chan_o(play_chan), .play_addr_o(play_addr), .bank_o(bank),
    .playing_o(playing), .env_wr_o(env_wr), .env_chan_o(env_chan), .env_data_o(env_data)
  );

  synth_engine_model #(.HEAD_LEN(HEAD_LEN), .TAIL_LEN(TAIL_LEN)) eng (
    .clk_i(clk_i), .reset_i(reset_i), .play_start_i(play_start), .play_stop_i(play_stop),
    .play_chan_i(play_chan), .tail_en_i(1'b1), .head_done_o(head_done),
    .tail_start_o(tail_start), .tail_done_o(tail_done)
  );

  // clock
  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle pulses are caught here, not polled
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (play_start) begin
      starts <= starts + 1;
      last_addr <= play_addr;
    end
    if (env_wr) begin
      envs <= envs + 1;
      last_env <= {env_chan, env_data};
    end
    if (adv_valid && adv_chan_o == 3'h5) adv_sum <= adv_sum + adv_count;
    if (cyc == MAX_CYC) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers and expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_count(input int code);
    return 4'(8 - 2 * code);
  endfunction
  function automatic int exp_steps(input int step, input int n);
    return (step * n) >> 12;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // each task lets one edge pass so no strobe rises in its release step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    rdv = rdata;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [19:0] imm);
    wr(`REG_COMMAND_OFF, {4'h0, imm, 4'h0, op});
  endtask

  task automatic tst(input logic [3:0] op, input logic expv);
    cmd(op, 20'h0);
    rd_reg(`REG_STATUS_OFF);
    chk("status", {31'h0, rdv[0]}, {31'h0, expv});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CHANCFG_OFF, i);
      chk("count", count, exp_count(i));
    end
    wr(`REG_CHANCFG_OFF, 32'h0);
    cmd(`OP_BANK1, 20'h0);
    chk("bank", bank, 1'b1);
    rd_reg(8'h40);
    chk("unmapped", rdv, 32'h0);
    cmd(`OP_BANK0, 20'h0);
    chk("bank", bank, 1'b0);
    for (int v = 0; v < 16; v++) begin
      wr(`REG_VOLUME_OFF, v);
      chk("volume", volume, v);
    end
    // mixer register both ways
    wr(`REG_ENABLE_OFF, 32'h8);
    chk("mixer_en", mixer_en, 1'b1);
    s = rnd();
    mix_valid <= 1'b1;
    mix_sample <= s[12:0];
    @(posedge clk_i);
    mix_valid <= 1'b0;
    @(posedge clk_i);
    chk("mix_data", mix_data, s[12:0]);
    cmd(`OP_READ_MIX, 20'h0);
    rd_reg(`REG_POINTER_OFF);
    chk("ptr_mix", rdv[12:0], s[12:0]);
    wr(`REG_ENABLE_OFF, 32'h0);
    chk("mixer_en", mixer_en, 1'b0);
    p = rnd();
    wr(`REG_POINTER_OFF, {8'h0, p[23:0]});
    cmd(`OP_WRITE_MIX, 20'h0);
    chk("mix_wr", mix_data, p[12:0]);
    // audio on in push-pull after the mixer settles
    wr(`REG_ENABLE_OFF, 32'h8);
    repeat (32) @(posedge clk_i);
    wr(`REG_ENABLE_OFF, 32'ha);
    chk("audio_en", aud, 1'b1);
    rd_reg(`REG_STATUS_OFF);
    chk("ramp_busy", rdv[1], 1'b1);
    for (int t = 0; t < 1100 && ramp; t++) @(posedge clk_i);
    chk("ramp", ramp, 1'b0);
    // envelope only moves on the high nibble
    wr(`REG_CHSEL_OFF, 32'h3);
    r = rnd();
    wr(`REG_ENVLOW_OFF, {28'h0, r[3:0]});
    chk("env_cnt", envs, 0);
    wr(`REG_ENVHIGH_OFF, {28'h0, r[7:4]});
    chk("env_cnt", envs, 1);
    chk("env", last_env, {3'h3, r[7:0]});
    // step accumulation, kept below the quality limit
    s = rnd() & 32'h0fff;
    wr(`REG_POINTER_OFF, s);
    wr(`REG_CHSEL_OFF, 32'h5);
    cmd(`OP_LOAD_STEP, 20'h0);
    for (int i = 0; i < 16; i++) begin
      adv_req <= 1'b1;
      adv_chan <= 3'h5;
      @(posedge clk_i);
    end
    adv_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("advance", adv_sum, exp_steps(s, 16));
    // head then tail on a random channel
    r = rnd();
    c = r[26:24];
    wr(`REG_CHSEL_OFF, {29'h0, c});
    cmd(`OP_BEGIN_IMM, r[19:0]);
    chk("start_addr", last_addr, {r[19:0], 4'h0});
    tst(`OP_TEST_HEAD_ACTIVE, 1'b1);
    tst(`OP_TEST_ALL_IDLE, 1'b0);
    wr(`REG_CHSEL_OFF, {29'h0, c ^ 3'h1});
    tst(`OP_TEST_ACTIVE, 1'b0);
    wr(`REG_CHSEL_OFF, {29'h0, c});
    repeat (HEAD_LEN) @(posedge clk_i);
    tst(`OP_TEST_HEAD_IDLE, 1'b1);
    tst(`OP_TEST_ACTIVE, 1'b1);
    repeat (TAIL_LEN) @(posedge clk_i);
    tst(`OP_TEST_IDLE, 1'b1);
    tst(`OP_TEST_ALL_IDLE, 1'b1);
    // restart from the pointer with a dirty low nibble, then stop
    p = rnd();
    wr(`REG_POINTER_OFF, {8'h0, p[23:4], 4'h7});
    cmd(`OP_BEGIN, 20'h0);
    chk("start_addr", last_addr, {p[23:4], 4'h0});
    chk("starts", starts, 2);
    cmd(`OP_STOP, 20'h0);
    tst(`OP_TEST_IDLE, 1'b1);
    chk("playing", playing[c], 1'b0);
    stop_test();
  end
endmodule
